// ### include/pwm_cfg_pkg.sv
`default_nettype none
package pwm_cfg_pkg;
	localparam int unsigned addr_w = 4;
	localparam logic [addr_w-1:0] off_duty = 4'h0;
	localparam logic [addr_w-1:0] off_phase = 4'h4;
	localparam logic [addr_w-1:0] off_fault_limit = 4'h8;
	localparam logic [addr_w-1:0] off_gen_ctrl = 4'hc;
	localparam logic [15:0] duty_reset = 16'h0000;
	localparam logic [15:0] phase_reset = 16'h0000;
	// limit source 0, fault source all ones
	localparam logic [15:0] fault_limit_reset = 16'h00f8;
	localparam logic [15:0] fault_limit_mask = 16'h7fff;
	localparam int unsigned limit_src_lsb = 10;
	localparam int unsigned limit_pol_bit = 9;
	localparam int unsigned limit_mode_bit = 8;
	localparam int unsigned fault_src_lsb = 3;
	localparam int unsigned fault_pol_bit = 2;
	localparam int unsigned fault_mode_lsb = 0;
	localparam int unsigned itb_bit = 0;
	localparam int unsigned pairing_lsb = 1;
	localparam logic [2:0] gen_ctrl_reset = 3'h0;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	localparam logic [4:0] limit_src_reserved = 5'h1e;
	// output pairing codes: complementary, redundant, push-pull
	localparam logic [1:0] pair_compl = 2'h0;
	localparam logic [1:0] pair_redund = 2'h1;
	localparam logic [1:0] pair_pushpull = 2'h2;
endpackage
`default_nettype wire

// ### rtl/pwm_duty_phase_limit_cfg.sv
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_phase_limit_cfg (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [15:0] duty_cycle_value,
	output logic [15:0] phase_offset,
	output logic [15:0] base_period,
	output logic phase_offset_valid,
	output logic base_period_valid,
	output logic [4:0] limit_source_select,
	output logic limit_polarity,
	output logic limit_mode_enable,
	output logic [4:0] fault_source_select,
	output logic fault_polarity,
	output logic [1:0] fault_response_field
);
	logic [15:0] phase_or_period_value, fault_limit_control;
	logic [2:0] generator_control_reg;
	logic [15:0] next_duty, next_phase, next_fault;
	logic [2:0] next_gen;
	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [3:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic [15:0] next_phase_offset, next_base_period;
	logic next_phase_ok, next_period_ok;
	logic do_write;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic mapped(input logic [3:0] a);
		mapped = (a == pwm_cfg_pkg::off_duty) || (a == pwm_cfg_pkg::off_phase)
			|| (a == pwm_cfg_pkg::off_fault_limit) || (a == pwm_cfg_pkg::off_gen_ctrl);
	endfunction

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_duty = duty_cycle_value;
		next_phase = phase_or_period_value;
		next_fault = fault_limit_control;
		next_gen = generator_control_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(aw_addr) ? pwm_cfg_pkg::resp_okay : pwm_cfg_pkg::resp_slverr;
			case (aw_addr)
				pwm_cfg_pkg::off_duty: next_duty = merge16(duty_cycle_value, w_data, w_strb);
				pwm_cfg_pkg::off_phase: next_phase = merge16(phase_or_period_value, w_data, w_strb);
				pwm_cfg_pkg::off_fault_limit:
					next_fault = merge16(fault_limit_control, w_data, w_strb) & pwm_cfg_pkg::fault_limit_mask;
				pwm_cfg_pkg::off_gen_ctrl: if (w_strb[0]) next_gen = w_data[2:0];
				default: next_gen = generator_control_reg;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pwm_cfg_pkg::resp_okay;
			duty_cycle_value <= pwm_cfg_pkg::duty_reset;
			phase_or_period_value <= pwm_cfg_pkg::phase_reset;
			fault_limit_control <= pwm_cfg_pkg::fault_limit_reset;
			generator_control_reg <= pwm_cfg_pkg::gen_ctrl_reset;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			duty_cycle_value <= next_duty;
			phase_or_period_value <= next_phase;
			fault_limit_control <= next_fault;
			generator_control_reg <= next_gen;
		end
	end

	// ready registered from holding state so it comes from a flip-flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// read channel: one outstanding read, arready only while idle
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = mapped(s_axi_araddr) ? pwm_cfg_pkg::resp_okay : pwm_cfg_pkg::resp_slverr;
			case (s_axi_araddr)
				pwm_cfg_pkg::off_duty: next_rdata = {16'h0000, duty_cycle_value};
				pwm_cfg_pkg::off_phase: next_rdata = {16'h0000, phase_or_period_value};
				pwm_cfg_pkg::off_fault_limit: next_rdata = {16'h0000, fault_limit_control};
				pwm_cfg_pkg::off_gen_ctrl: next_rdata = {29'h0, generator_control_reg};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= pwm_cfg_pkg::resp_okay;
		end else begin
			s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// phase value steering by independent base select and pairing mode
	always_comb begin
		logic pair_ok;
		logic independent_base_select;
		pair_ok = 1'b0;
		independent_base_select = next_gen[pwm_cfg_pkg::itb_bit];
		case (next_gen[pwm_cfg_pkg::pairing_lsb +: 2])
			pwm_cfg_pkg::pair_compl, pwm_cfg_pkg::pair_redund, pwm_cfg_pkg::pair_pushpull: pair_ok = 1'b1;
			default: pair_ok = 1'b0;
		endcase
		next_phase_ok = pair_ok && !independent_base_select;
		next_period_ok = pair_ok && independent_base_select;
		next_phase_offset = next_phase_ok ? next_phase : 16'h0000;
		next_base_period = next_period_ok ? next_phase : 16'h0000;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// control resets to complementary with base clear, so the phase value is an offset
			phase_offset <= pwm_cfg_pkg::phase_reset;
			base_period <= 16'h0000;
			phase_offset_valid <= 1'b1;
			base_period_valid <= 1'b0;
			limit_source_select <= pwm_cfg_pkg::fault_limit_reset[pwm_cfg_pkg::limit_src_lsb +: 5];
			limit_polarity <= 1'b0;
			limit_mode_enable <= 1'b0;
			fault_source_select <= pwm_cfg_pkg::fault_limit_reset[pwm_cfg_pkg::fault_src_lsb +: 5];
			fault_polarity <= 1'b0;
			fault_response_field <= 2'h0;
		end else begin
			phase_offset <= next_phase_offset;
			base_period <= next_base_period;
			phase_offset_valid <= next_phase_ok;
			base_period_valid <= next_period_ok;
			limit_source_select <= next_fault[pwm_cfg_pkg::limit_src_lsb +: 5];
			limit_polarity <= next_fault[pwm_cfg_pkg::limit_pol_bit];
			limit_mode_enable <= next_fault[pwm_cfg_pkg::limit_mode_bit];
			fault_source_select <= next_fault[pwm_cfg_pkg::fault_src_lsb +: 5];
			fault_polarity <= next_fault[pwm_cfg_pkg::fault_pol_bit];
			fault_response_field <= next_fault[pwm_cfg_pkg::fault_mode_lsb +: 2];
		end
	end

	chk_duty_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && aw_addr == pwm_cfg_pkg::off_duty && w_strb == 4'hf |=> duty_cycle_value == $past(w_data[15:0]))
		else $error("duty value not stored");
	chk_phase_offset_use: assert property (@(posedge aclk) disable iff (!aresetn)
		!generator_control_reg[0] && generator_control_reg[2:1] != 2'h3 |-> phase_offset_valid && !base_period_valid)
		else $error("phase offset not selected");
	chk_period_use: assert property (@(posedge aclk) disable iff (!aresetn)
		base_period_valid |-> base_period == phase_or_period_value && generator_control_reg[0])
		else $error("period not selected");
	chk_pair_mode_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		generator_control_reg[2:1] == 2'h3 |-> !phase_offset_valid && !base_period_valid)
		else $error("mode 11 used phase value");
	chk_top_bit_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		!fault_limit_control[15] && (!s_axi_rvalid || s_axi_rdata[31:16] == 16'h0000))
		else $error("unimplemented bit nonzero");
	chk_limit_src_field: assert property (@(posedge aclk) disable iff (!aresetn)
		limit_source_select == fault_limit_control[14:10])
		else $error("limit source mismatch");
	chk_limit_src_reset: assert property (@(posedge aclk)
		!aresetn |=> limit_source_select == 5'h00 && fault_limit_control == 16'h00f8)
		else $error("limit source reset wrong");
	chk_limit_pol_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		limit_polarity == fault_limit_control[9] && limit_mode_enable == fault_limit_control[8])
		else $error("limit polarity mismatch");
endmodule // pwm_duty_phase_limit_cfg
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, fault_response_field, r;
	logic [15:0] duty_cycle_value, phase_offset, base_period;
	logic phase_offset_valid, base_period_valid, limit_polarity, limit_mode_enable, fault_polarity;
	logic [4:0] limit_source_select, fault_source_select;
	logic [31:0] d;
	int errors = 0, comparisons = 0, cyc = 0;
	pwm_duty_phase_limit_cfg dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .duty_cycle_value,
		.phase_offset, .base_period, .phase_offset_valid, .base_period_valid, .limit_source_select, .limit_polarity,
		.limit_mode_enable, .fault_source_select, .fault_polarity, .fault_response_field);
	always #2 aclk = ~aclk;
	task automatic conclude;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ceiling well above the hundred-odd cycles the run needs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// each channel lets go only at the edge that takes it; a pending nba hides valid here
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic t_reset_values;
		rd(pwm_cfg_pkg::off_duty);
		chk(d, 32'h0);
		rd(pwm_cfg_pkg::off_phase);
		chk(d, 32'h0);
		rd(pwm_cfg_pkg::off_fault_limit);
		chk(d, 32'h0000_00f8);
		rd(pwm_cfg_pkg::off_gen_ctrl);
		chk(d, 32'h0);
		chk({phase_offset_valid, base_period_valid}, 2'h2);
		chk(limit_source_select, 5'h00);
		chk(fault_source_select, 5'h1f);
	endtask
	task automatic t_duty;
		wr(pwm_cfg_pkg::off_duty, 32'hffff_ffff, 4'hf);
		chk(r, pwm_cfg_pkg::resp_okay);
		rd(pwm_cfg_pkg::off_duty);
		chk(d, 32'h0000_ffff);
		chk(duty_cycle_value, 16'hffff);
		wr(pwm_cfg_pkg::off_duty, 32'h0000_ab00, 4'h2);
		rd(pwm_cfg_pkg::off_duty);
		chk(d, 32'h0000_abff);
	endtask
	task automatic t_limit;
		wr(pwm_cfg_pkg::off_fault_limit, 32'hffff_ffff, 4'hf);
		rd(pwm_cfg_pkg::off_fault_limit);
		chk(d, 32'h0000_7fff);
		chk(limit_source_select, 5'h1f);
		chk(limit_polarity, 1'b1);
		chk(limit_mode_enable, 1'b1);
		chk({fault_source_select, fault_polarity, fault_response_field}, 8'hff);
		wr(pwm_cfg_pkg::off_fault_limit, 32'h0000_2000, 4'hf);
		chk(limit_source_select, 5'h08);
		chk(limit_polarity, 1'b0);
	endtask
	task automatic t_phase_modes;
		logic [2:0] m;
		logic on;
		wr(pwm_cfg_pkg::off_phase, 32'h0000_1234, 4'h3);
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			on = (m[2:1] != 2'h3);
			wr(pwm_cfg_pkg::off_gen_ctrl, {29'h0, m}, 4'h1);
			@(posedge aclk);
			chk(phase_offset, (on && !m[0]) ? 16'h1234 : 16'h0);
			chk(base_period, (on && m[0]) ? 16'h1234 : 16'h0);
			chk({phase_offset_valid, base_period_valid}, {on && !m[0], on && m[0]});
			rd(pwm_cfg_pkg::off_gen_ctrl);
			chk(d, {29'h0, m});
		end
		// control bits live in lane 0 only, so this write must leave mode 7 in place
		wr(pwm_cfg_pkg::off_gen_ctrl, 32'h0000_0002, 4'he);
		rd(pwm_cfg_pkg::off_gen_ctrl);
		chk(d, 32'h0000_0007);
	endtask
	task automatic t_unmapped;
		wr(4'h2, 32'h0000_5555, 4'hf);
		chk(r, pwm_cfg_pkg::resp_slverr);
		rd(4'h2);
		chk(r, pwm_cfg_pkg::resp_slverr);
		chk(d, 32'h0);
		rd(pwm_cfg_pkg::off_duty);
		chk(d, 32'h0000_abff);
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset_values();
		t_duty();
		t_limit();
		t_phase_modes();
		t_unmapped();
		conclude();
	end
endmodule // tb_top
`default_nettype wire
